// ==== rtcb_core.sv ====
// backup real-time clock: counters, alarm, calibration, coin cell control
// Function
// - slow time base divided to one-second tick; tick advances 17-bit seconds
// - seconds count 0 to 86399, then wrap to zero
// - each wrap increments 15-bit date counter, max 32767
// - every tick sets tick flag; interrupt only when unmasked
// - alarm flag set when seconds and date both equal alarm values
// - alarm match turns on if powered off, else only interrupts
// - alarm mask high blocks alarm interrupt and turn-on
// - alarm mask resets to one
// - alarm seconds and date initialise to all ones on cell reset
// - alarm flag kept in backup domain, valid at main power-up
// - clock disable bit stops clock; resets to running
// - backup undervoltage reset clears clock and loads backed registers with their reset values
// - after backup reset, clock reset flag is set
// - signed 5-bit calibration adjusts 32768-cycle divider while active
// - correction equals signed word in counts per 32768 cycles
// - calibration never touches slow clock outputs
// - mode 00 off, 01 off on cell only, 11 on, 10 reserved
// - switch to backup when main undervolted and backup above main
// - connect cell on power on or on charger enable while on; disconnect below threshold
// - 3-bit charger voltage selects 2.50 to 3.30 volts
// - charge high current in on, low in off states; stop on undervolt
// - charger enable cleared by a zero write or by backup reset
// - backup regulator enabled from backup reset, never switchable off
`timescale 1ns/1ns
module rtcb_core #(
    parameter int DIV_COUNT = 32768
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow_en,
    input wire logic clock_disable,
    input wire logic [rtcb_pkg::SEC_W-1:0] alarm_seconds_wr,
    input wire logic [rtcb_pkg::DAY_W-1:0] alarm_date_wr,
    input wire logic alarm_wr,
    input wire logic alarm_irq_mask_wr,
    input wire logic alarm_irq_mask_val,
    input wire logic tick_irq_mask,
    input wire logic clock_reset_irq_mask,
    input wire rtcb_pkg::rtcb_irq_s irq_clear,
    input wire logic [rtcb_pkg::CAL_W-1:0] calibration_word,
    input wire logic [1:0] calibration_mode,
    input wire logic charger_enable_wr,
    input wire logic charger_enable_val,
    input wire logic [2:0] charger_voltage_select,
    input wire rtcb_pkg::rtcb_pwr_e power_state,
    input wire rtcb_pkg::rtcb_supply_s supply,
    output logic [rtcb_pkg::SEC_W-1:0] seconds_counter,
    output logic [rtcb_pkg::DAY_W-1:0] date_counter,
    output logic [rtcb_pkg::SEC_W-1:0] alarm_seconds,
    output logic [rtcb_pkg::DAY_W-1:0] alarm_date,
    output logic alarm_irq_mask,
    output rtcb_pkg::rtcb_irq_s irq_flags,
    output rtcb_pkg::rtcb_irq_s irq_out,
    output logic turn_on_event,
    output logic tick,
    output logic on_backup,
    output logic cell_connected,
    output logic charger_enable,
    output logic [2:0] charge_voltage,
    output logic charge_current_high,
    output logic charge_current_low,
    output logic backup_domain_regulator
);
    // sys_rst stands for the coin-cell power-on reset of this domain
    logic [rtcb_pkg::DIV_W-1:0] div_cnt;
    logic [rtcb_pkg::DIV_W-1:0] next_div_cnt;
    logic [rtcb_pkg::SEC_W-1:0] next_seconds;
    logic [rtcb_pkg::DAY_W-1:0] next_date;
    logic next_tick;
    logic [rtcb_pkg::SEC_W-1:0] next_alarm_seconds;
    logic [rtcb_pkg::DAY_W-1:0] next_alarm_date;
    logic next_alarm_mask;
    logic next_turn_on;
    logic por_pending;
    logic next_por_pending;
    logic cal_active;
    logic [rtcb_pkg::DIV_W-1:0] div_last;
    logic alarm_match;
    logic next_on_backup;
    logic next_connected;
    logic next_charger_enable;
    logic [2:0] next_charge_voltage;
    logic next_chg_hi;
    logic next_chg_lo;
    logic was_on;
    logic next_was_on;
    logic connect_event;

    // divider end point, shifted by the signed calibration word
    always_comb begin
        cal_active = 1'b0;
        case (calibration_mode)
            rtcb_pkg::CAL_MODE_ALL: cal_active = 1'b1;
            rtcb_pkg::CAL_MODE_MAIN: cal_active = ~on_backup;
            rtcb_pkg::CAL_MODE_OFF: cal_active = 1'b0;
            default: cal_active = 1'b0;
        endcase
        div_last = rtcb_pkg::DIV_W'(DIV_COUNT - 1);
        if (cal_active) begin
            // positive word gives a shorter second
            div_last = rtcb_pkg::DIV_W'(DIV_COUNT - 1
                - $signed(calibration_word));
        end
    end

    // divider and counters; slow clock outputs are not touched
    always_comb begin
        next_div_cnt = div_cnt;
        next_tick = 1'b0;
        next_seconds = seconds_counter;
        next_date = date_counter;
        if (slow_en && !clock_disable) begin
            if (div_cnt >= div_last) begin
                next_div_cnt = '0;
                next_tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 1'b1;
            end
        end
        if (tick) begin
            if (seconds_counter >= rtcb_pkg::SEC_LAST) begin
                next_seconds = '0;
                next_date = date_counter + 1'b1;
            end else begin
                next_seconds = seconds_counter + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt <= '0;
            tick <= 1'b0;
            seconds_counter <= '0;
            date_counter <= '0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
            seconds_counter <= next_seconds;
            date_counter <= next_date;
        end
    end

    // alarm, compared on the cycle after each tick so it matches once
    assign alarm_match = (seconds_counter == alarm_seconds)
        && (date_counter == alarm_date);
    logic tick_d;

    always_comb begin
        next_alarm_seconds = alarm_seconds;
        next_alarm_date = alarm_date;
        next_alarm_mask = alarm_irq_mask;
        next_por_pending = 1'b0;
        if (alarm_wr) begin
            next_alarm_seconds = alarm_seconds_wr;
            next_alarm_date = alarm_date_wr;
        end
        if (alarm_irq_mask_wr) begin
            next_alarm_mask = alarm_irq_mask_val;
        end
        // turn-on only when off and unmasked
        next_turn_on = tick_d && alarm_match && !alarm_irq_mask
            && (power_state != rtcb_pkg::RTCB_PWR_ON);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alarm_seconds <= rtcb_pkg::ALARM_SEC_RESET;
            alarm_date <= rtcb_pkg::ALARM_DAY_RESET;
            alarm_irq_mask <= rtcb_pkg::ALARM_MASK_RESET;
            por_pending <= 1'b1;
            turn_on_event <= 1'b0;
            tick_d <= 1'b0;
        end else begin
            alarm_seconds <= next_alarm_seconds;
            alarm_date <= next_alarm_date;
            alarm_irq_mask <= next_alarm_mask;
            por_pending <= next_por_pending;
            turn_on_event <= next_turn_on;
            tick_d <= tick;
        end
    end

    // sticky flags, set wins over clear
    rtcb_irq_flag u_tick_flag (
        .clk(clk),
        .rst(sys_rst),
        .set(tick),
        .clr(irq_clear.tick),
        .mask(tick_irq_mask),
        .flag(irq_flags.tick),
        .irq(irq_out.tick)
    );

    rtcb_irq_flag u_alarm_flag (
        .clk(clk),
        .rst(sys_rst),
        .set(tick_d && alarm_match),
        .clr(irq_clear.alarm),
        .mask(alarm_irq_mask),
        .flag(irq_flags.alarm),
        .irq(irq_out.alarm)
    );

    rtcb_irq_flag u_reset_flag (
        .clk(clk),
        .rst(sys_rst),
        .set(por_pending),
        .clr(irq_clear.clock_reset),
        .mask(clock_reset_irq_mask),
        .flag(irq_flags.clock_reset),
        .irq(irq_out.clock_reset)
    );

    // coin cell switchover, connection and charger
    always_comb begin
        next_on_backup = supply.main_undervolt && supply.backup_above_main;
        next_charger_enable = charger_enable;
        if (charger_enable_wr) begin
            next_charger_enable = charger_enable_val;
        end
        next_was_on = (power_state == rtcb_pkg::RTCB_PWR_ON);
        // connect only on turning on, or on charger enable while on
        connect_event = (power_state == rtcb_pkg::RTCB_PWR_ON)
            && (!was_on || (next_charger_enable && !charger_enable));
        next_connected = cell_connected;
        if (!supply.backup_above_disc) begin
            next_connected = 1'b0;
        end else if (connect_event) begin
            next_connected = 1'b1;
        end
        next_charge_voltage = charger_voltage_select;
        next_chg_hi = 1'b0;
        next_chg_lo = 1'b0;
        if (charger_enable && !supply.main_undervolt) begin
            case (power_state)
                rtcb_pkg::RTCB_PWR_ON: next_chg_hi = 1'b1;
                rtcb_pkg::RTCB_PWR_OFF: next_chg_lo = 1'b1;
                rtcb_pkg::RTCB_PWR_USER_OFF: next_chg_lo = 1'b1;
                default: next_chg_lo = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            on_backup <= 1'b0;
            cell_connected <= 1'b0;
            was_on <= 1'b0;
            charger_enable <= 1'b0;
            charge_voltage <= rtcb_pkg::CHG_VOLT_RESET;
            charge_current_high <= 1'b0;
            charge_current_low <= 1'b0;
            backup_domain_regulator <= 1'b1;
        end else begin
            on_backup <= next_on_backup;
            cell_connected <= next_connected;
            was_on <= next_was_on;
            charger_enable <= next_charger_enable;
            charge_voltage <= next_charge_voltage;
            charge_current_high <= next_chg_hi;
            charge_current_low <= next_chg_lo;
            backup_domain_regulator <= 1'b1;
        end
    end
endmodule : rtcb_core

// ==== rtcb_pkg.sv ====
// package: constants and carriers for the backup real-time clock block
package rtcb_pkg;
    localparam int SEC_W = 17;
    localparam int DAY_W = 15;
    localparam int CAL_W = 5;
    localparam int DIV_W = 16;
    localparam logic [SEC_W-1:0] SEC_LAST = 17'h1_517F;
    localparam logic [DAY_W-1:0] DAY_LAST = 15'h7FFF;
    localparam logic [DIV_W-1:0] DIV_NOMINAL = 16'h8000;
    localparam logic [SEC_W-1:0] ALARM_SEC_RESET = 17'h1_FFFF;
    localparam logic [DAY_W-1:0] ALARM_DAY_RESET = 15'h7FFF;
    localparam logic ALARM_MASK_RESET = 1'b1;
    localparam logic CLOCK_DISABLE_RESET = 1'b0;
    localparam logic [1:0] CAL_MODE_RESET = 2'h0;
    localparam logic [1:0] CAL_MODE_OFF = 2'h0;
    localparam logic [1:0] CAL_MODE_MAIN = 2'h1;
    localparam logic [1:0] CAL_MODE_RSVD = 2'h2;
    localparam logic [1:0] CAL_MODE_ALL = 2'h3;
    localparam logic [2:0] CHG_VOLT_RESET = 3'h0;
    // slow time base rate and sys clock rate
    localparam int SLOW_HZ = 32768;
    localparam int CLK_MHZ = 250;

    typedef enum logic [2:0] {
        RTCB_PWR_OFF = 3'b001,
        RTCB_PWR_USER_OFF = 3'b010,
        RTCB_PWR_ON = 3'b100
    } rtcb_pwr_e;

    typedef struct packed {
        logic main_undervolt;
        logic backup_above_main;
        logic backup_above_disc;
    } rtcb_supply_s;

    typedef struct packed {
        logic tick;
        logic alarm;
        logic clock_reset;
    } rtcb_irq_s;
endpackage : rtcb_pkg

// ==== rtcb_irq_flag.sv ====
// one sticky event flag with mask, set wins over clear
`timescale 1ns/1ns
module rtcb_irq_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    input wire logic mask,
    output logic flag,
    output logic irq
);
    logic next_flag;
    logic next_irq;

    always_comb begin
        next_flag = set | (flag & ~clr);
        next_irq = next_flag & ~mask;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            flag <= next_flag;
            irq <= next_irq;
        end
    end
endmodule : rtcb_irq_flag

// ==== rtcb_slow_src.sv ====
// partner: slow time base strobe with programmable spacing
`timescale 1ns/1ns
module rtcb_slow_src (
    input wire logic clk,
    input wire logic [3:0] gap,
    output logic slow_en
);
    logic [3:0] cnt = 4'h0;
    logic hit = 1'b0;
    assign slow_en = hit;
    always_ff @(posedge clk) begin
        cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
        hit <= (cnt >= gap);
    end
endmodule : rtcb_slow_src

// ==== rtcb_core_sva.sv ====
// checker: port-level timing of the backup clock core
`timescale 1ns/1ns
module rtcb_core_sva #(
    parameter int DIV_COUNT = 32768
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clock_disable,
    input wire logic alarm_irq_mask,
    input wire logic [rtcb_pkg::SEC_W-1:0] seconds_counter,
    input wire logic [rtcb_pkg::DAY_W-1:0] date_counter,
    input wire logic [rtcb_pkg::SEC_W-1:0] alarm_seconds,
    input wire logic [rtcb_pkg::DAY_W-1:0] alarm_date,
    input wire rtcb_pkg::rtcb_irq_s irq_flags,
    input wire rtcb_pkg::rtcb_irq_s irq_out,
    input wire logic turn_on_event,
    input wire logic tick,
    input wire logic charger_enable,
    input wire logic charger_enable_wr,
    input wire logic charger_enable_val
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic last;
    logic match;
    assign last = seconds_counter == rtcb_pkg::SEC_LAST;
    assign match = seconds_counter == alarm_seconds
        && date_counter == alarm_date;
    property p_step;
        tick && !last |=> seconds_counter == $past(seconds_counter) + 1'b1;
    endproperty
    a_step: assert property (p_step)
        else $error("seconds did not step");
    property p_wrap;
        tick && last |=> seconds_counter == '0
            && date_counter == $past(date_counter) + 1'b1;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("seconds wrap wrong");
    property p_hold;
        !tick |=> $stable(seconds_counter);
    endproperty
    a_hold: assert property (p_hold)
        else $error("seconds moved without tick");
    property p_tflag;
        tick |=> irq_flags.tick;
    endproperty
    a_tflag: assert property (p_tflag)
        else $error("tick flag missing");
    property p_amask;
        alarm_irq_mask [*2] |-> !irq_out.alarm && !turn_on_event;
    endproperty
    a_amask: assert property (p_amask)
        else $error("masked alarm escaped");
    property p_aset;
        tick ##1 match |=> irq_flags.alarm;
    endproperty
    a_aset: assert property (p_aset)
        else $error("alarm flag missing");
    property p_rvals;
        $fell(sys_rst) |-> alarm_irq_mask && seconds_counter == '0
            && alarm_seconds == rtcb_pkg::ALARM_SEC_RESET;
    endproperty
    a_rvals: assert property (p_rvals)
        else $error("reset values wrong");
    property p_rflag;
        $fell(sys_rst) |-> ##[1:2] irq_flags.clock_reset;
    endproperty
    a_rflag: assert property (p_rflag)
        else $error("clock reset flag missing");
    property p_chg;
        charger_enable && !charger_enable_wr |=> charger_enable;
    endproperty
    a_chg: assert property (p_chg)
        else $error("charger enable dropped");
    property p_chgw;
        charger_enable_wr |=> charger_enable == $past(charger_enable_val);
    endproperty
    a_chgw: assert property (p_chgw)
        else $error("charger enable write lost");
    property p_dis;
        clock_disable [*2] |-> !tick;
    endproperty
    a_dis: assert property (p_dis)
        else $error("tick while disabled");
    c_wrap: cover property (tick && last);
    c_alarm: cover property ($rose(irq_flags.alarm));
    c_ton: cover property (turn_on_event);
endmodule : rtcb_core_sva
bind rtcb_core rtcb_core_sva #(.DIV_COUNT(DIV_COUNT)) u_sva (
    .clk, .sys_rst, .clock_disable, .alarm_irq_mask, .seconds_counter,
    .date_counter, .alarm_seconds, .alarm_date, .irq_flags, .irq_out,
    .turn_on_event, .tick, .charger_enable, .charger_enable_wr,
    .charger_enable_val
);

// ==== tb_rtcb_core.sv ====
// testbench: random and corner stimulus for the backup clock core
`timescale 1ns/1ns
module tb_rtcb_core;
    localparam int DIV = 16;
    logic clk, sys_rst, slow_en, clock_disable, alarm_wr, tick_irq_mask;
    logic alarm_irq_mask_wr, alarm_irq_mask_val, clock_reset_irq_mask;
    logic charger_enable_wr, charger_enable_val, alarm_irq_mask, tick;
    logic [16:0] alarm_seconds_wr, seconds_counter, alarm_seconds, s0;
    logic [14:0] alarm_date_wr, date_counter, alarm_date;
    logic [4:0] calibration_word;
    logic [1:0] calibration_mode;
    logic [2:0] charger_voltage_select, charge_voltage;
    logic turn_on_event, on_backup, cell_connected, charger_enable;
    logic charge_current_high, charge_current_low, backup_domain_regulator;
    logic [3:0] gap;
    rtcb_pkg::rtcb_irq_s irq_clear, irq_flags, irq_out;
    rtcb_pkg::rtcb_pwr_e power_state;
    rtcb_pkg::rtcb_supply_s supply;
    logic [31:0] lfsr = 32'h0000_928e;
    logic [4:0] corner [4] = '{5'h0f, 5'h10, 5'h1f, 5'h10};
    int miscompares = 0, n_checks = 0, nton = 0;
    rtcb_core #(.DIV_COUNT(DIV)) dut (
        .clk, .sys_rst, .slow_en, .clock_disable, .alarm_seconds_wr,
        .alarm_date_wr, .alarm_wr, .alarm_irq_mask_wr, .alarm_irq_mask_val,
        .tick_irq_mask, .clock_reset_irq_mask, .irq_clear, .calibration_word,
        .calibration_mode, .charger_enable_wr, .charger_enable_val,
        .charger_voltage_select, .power_state, .supply, .seconds_counter,
        .date_counter, .alarm_seconds, .alarm_date, .alarm_irq_mask,
        .irq_flags, .irq_out, .turn_on_event, .tick, .on_backup,
        .cell_connected, .charger_enable, .charge_voltage,
        .charge_current_high, .charge_current_low, .backup_domain_regulator
    );
    rtcb_slow_src u_src (.clk, .gap, .slow_en);
    function automatic logic [31:0] rnd(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : rnd
    function automatic int exp_per(logic [4:0] c, logic [1:0] m, logic bk);
        if (m == rtcb_pkg::CAL_MODE_ALL || (m == 2'h1 && !bk)) begin
            return DIV - $signed(c);
        end
        return DIV;
    endfunction : exp_per
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s exp %0h got %0h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic wait_tick(output int n);
        n = 0;
        for (int i = 0; i < 4000; i++) begin
            @(posedge clk);
            #1;
            n += (slow_en && !clock_disable);
            if (tick === 1'b1) return;
        end
        miscompares++;
        wrap_up();
    endtask : wait_tick
    task automatic do_reset;
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
    endtask : do_reset
    task automatic meas(logic [4:0] c, logic [1:0] m, logic bk);
        int n;
        @(negedge clk);
        calibration_word = c;
        calibration_mode = m;
        supply = {bk, bk, 1'b1};
        gap = {2'h0, lfsr[6:5]} | 4'h1;
        wait_tick(n);
        wait_tick(n);
        chk("period", exp_per(c, m, bk), n);
        chk("on_backup", bk, on_backup);
    endtask : meas
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {clock_disable, alarm_wr, alarm_irq_mask_wr, tick_irq_mask} = '0;
        {alarm_irq_mask_val, clock_reset_irq_mask, charger_enable_wr} = '0;
        {charger_enable_val, alarm_seconds_wr, alarm_date_wr} = '0;
        {calibration_word, calibration_mode, charger_voltage_select} = '0;
        irq_clear = '0;
        power_state = rtcb_pkg::RTCB_PWR_OFF;
        supply = 3'h1;
        gap = 4'h1;
        do_reset();
        @(negedge clk);
        chk("alm_d", rtcb_pkg::ALARM_DAY_RESET, alarm_date);
        chk("date", 0, date_counter);
        chk("regulator", 1, backup_domain_regulator);
        repeat (3) @(negedge clk);
        chk("rst_irq", 1, irq_out.clock_reset);
        for (int k = 0; k < 12; k++) begin
            lfsr = rnd(lfsr);
            meas(k < 4 ? corner[k] : lfsr[4:0], 2'h3 - k[1:0], k[3]);
        end
        @(negedge clk);
        clock_disable = 1'b1;
        tick_irq_mask = 1'b1;
        clock_reset_irq_mask = 1'b1;
        repeat (4) @(negedge clk);
        chk("tick_irq", 0, irq_out.tick);
        chk("rst_irq", 0, irq_out.clock_reset);
        tick_irq_mask = 1'b0;
        repeat (2) @(negedge clk);
        chk("tick_irq", 1, irq_out.tick);
        s0 = seconds_counter;
        irq_clear = '1;
        @(negedge clk);
        irq_clear = '0;
        repeat (200) @(negedge clk);
        chk("sec_held", s0, seconds_counter);
        chk("flags", 0, irq_flags);
        charger_enable_wr = 1'b1;
        charger_enable_val = 1'b1;
        for (int v = 0; v < 8; v++) begin
            @(negedge clk);
            charger_enable_wr = 1'b0;
            lfsr = rnd(lfsr);
            charger_voltage_select = v[2:0] ^ lfsr[2:0];
            supply = {v[2], 1'b0, 1'b1};
            power_state = v[0] ? rtcb_pkg::RTCB_PWR_ON :
                (v[1] ? rtcb_pkg::RTCB_PWR_USER_OFF : rtcb_pkg::RTCB_PWR_OFF);
            repeat (3) @(negedge clk);
            chk("volt", charger_voltage_select, charge_voltage);
            chk("chg_en", 1, charger_enable);
            chk("i_hi", v[0] & !v[2], charge_current_high);
            chk("i_lo", !v[0] & !v[2], charge_current_low);
            chk("cell", v != 0, cell_connected);
        end
        // cell drops below threshold, stays off until a new connect event
        supply = 3'h0;
        repeat (3) @(negedge clk);
        chk("cell", 0, cell_connected);
        supply = 3'h1;
        repeat (3) @(negedge clk);
        chk("cell", 0, cell_connected);
        {charger_enable_wr, charger_enable_val} = 2'h2;
        @(negedge clk);
        charger_enable_val = 1'b1;
        @(negedge clk);
        charger_enable_wr = 1'b0;
        repeat (2) @(negedge clk);
        chk("cell", 1, cell_connected);
        {charger_enable_wr, clock_disable} = '0;
        power_state = rtcb_pkg::RTCB_PWR_OFF;
        supply = 3'h1;
        gap = 4'h0;
        // one tick per cycle keeps the day wrap within the run
        {calibration_mode, calibration_word} = {2'h3, 5'h0f};
        do_reset();
        alarm_seconds_wr = 17'h0_0002;
        alarm_date_wr = 15'h0001;
        {alarm_wr, alarm_irq_mask_wr} = 2'h3;
        @(negedge clk);
        {alarm_wr, alarm_irq_mask_wr} = 2'h0;
        @(negedge clk);
        chk("alm_s", 2, alarm_seconds);
        for (int i = 0; i < 90000 && irq_flags.alarm !== 1'b1; i++) begin
            @(negedge clk);
            nton += turn_on_event;
        end
        chk("alarm_flag", 1, irq_flags.alarm);
        chk("alarm_irq", 1, irq_out.alarm);
        chk("date", 1, date_counter);
        repeat (20) begin
            @(negedge clk);
            nton += turn_on_event;
        end
        chk("turn_on", 1, nton);
        wrap_up();
    end
endmodule : tb_rtcb_core
